// ===== rtl/ppc_clock_ctrl.sv
// Prescaler, timer source select, frequency outputs and external clock gates.
// Assumes an AXI4-Lite master on i_clock and free-running oscillator pins.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module ppc_clock_ctrl
  import ppc_pkg::*;
#(
  parameter int FAST_CNT_W = 8,
  parameter int SLOW_CNT_W = 7
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // AXI4-Lite write address
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [PPC_ADDR_W-1:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  // AXI4-Lite write data
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [PPC_DATA_W-1:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // AXI4-Lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read address
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [PPC_ADDR_W-1:0] i_araddr,
  input wire logic [2:0] i_arprot,
  // AXI4-Lite read data
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [PPC_DATA_W-1:0] o_rdata,
  output logic [1:0] o_rresp,
  // Oscillator and counter clock pins
  input wire logic i_slow_osc_freq,
  input wire logic i_fast_osc_freq,
  input wire logic i_ext_counter_clk_a,
  input wire logic i_ext_counter_clk_b,
  // Clocks to timers
  output logic o_byte_timer_clk,
  output logic o_word_timer_a_clk,
  output logic o_word_timer_b_clk,
  output logic o_ext_clk_a,
  output logic o_ext_clk_b,
  // Frequency output pins
  output logic o_slow_freq_output,
  output logic o_fast_freq_output
);

  localparam int GATES = 5;
  localparam int G_BYTE = 0;
  localparam int G_SLOW = 1;
  localparam int G_FAST = 2;
  localparam int G_EXTB = 3;
  localparam int G_EXTA = 4;

  initial begin
    if (FAST_CNT_W != 8) $error("ppc_clock_ctrl: FAST_CNT_W must be 8 for /256");
    if (SLOW_CNT_W != 7) $error("ppc_clock_ctrl: SLOW_CNT_W must be 7 for /128");
  end

  ppc_ctrl_t ctrl_reg;
  logic aw_ready_reg;
  logic w_ready_reg;
  logic [PPC_ADDR_W-1:0] awaddr_reg;
  logic [PPC_DATA_W-1:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic ar_ready_reg;
  logic rvalid_reg;
  logic [PPC_DATA_W-1:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic wr_fire;
  ppc_sel_t wr_sel;
  ppc_sel_t rd_sel;

  logic slow_level;
  logic fast_level;
  logic ext_a_level;
  logic ext_b_level;
  logic [SLOW_CNT_W-1:0] slow_cnt;
  logic [FAST_CNT_W-1:0] fast_cnt;

  logic [GATES-1:0] gate_src;
  logic [GATES-1:0] gate_on;
  logic [GATES-1:0] gate_act_reg;
  logic [GATES-1:0] gate_out_reg;
  logic word_a_reg;
  logic word_b_reg;

  // Pin sampling
  ppc_osc_tap #(.CNT_W(SLOW_CNT_W)) u_slow_tap (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_pin(i_slow_osc_freq),
    .o_level(slow_level),
    .o_count(slow_cnt)
  );

  ppc_osc_tap #(.CNT_W(FAST_CNT_W)) u_fast_tap (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_pin(i_fast_osc_freq),
    .o_level(fast_level),
    .o_count(fast_cnt)
  );

  ppc_osc_tap #(.CNT_W(1)) u_ext_a_tap (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_pin(i_ext_counter_clk_a),
    .o_level(ext_a_level),
    .o_count()
  );

  ppc_osc_tap #(.CNT_W(1)) u_ext_b_tap (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_pin(i_ext_counter_clk_b),
    .o_level(ext_b_level),
    .o_count()
  );

  // Division tap: code 0 passes the level, code n takes count bit n-1
  function automatic logic tap_sel(input logic level, input logic [7:0] cnt,
                                   input logic [2:0] code);
    logic bit_out;
    bit_out = level;
    if (code != 3'h0) begin
      bit_out = cnt[code - 3'h1];
    end
    return bit_out;
  endfunction

  // Read view of the control set, unassigned bits zero
  function automatic logic [7:0] read_byte(input ppc_sel_t sel, input ppc_ctrl_t c);
    logic [7:0] val;
    val = 8'h00;
    case (sel)
      PPC_SEL_PRESCALE: begin
        val[PPC_POS_BT_ON] = c.byte_timer_clk_on;
        val[PPC_POS_BT_DIV +: 3] = c.byte_timer_div;
      end
      PPC_SEL_SRC: begin
        val[PPC_POS_SRC_B] = c.word_timer_b_src_sel;
        val[PPC_POS_SRC_A] = c.word_timer_a_src_sel;
      end
      PPC_SEL_FOUT: begin
        val[PPC_POS_SLOW_ON] = c.slow_out_on;
        val[PPC_POS_SLOW_DIV +: 3] = c.slow_out_div;
        val[PPC_POS_FAST_ON] = c.fast_out_on;
        val[PPC_POS_FAST_DIV +: 3] = c.fast_out_div;
      end
      PPC_SEL_EXT: begin
        val[PPC_POS_EXT_B] = c.ext_clk_b_gate;
        val[PPC_POS_EXT_A] = c.ext_clk_a_gate;
      end
      default: begin
        val = 8'h00;
      end
    endcase
    return val;
  endfunction

  // Write channel: address and data taken in either order, then one response
  assign wr_fire = !aw_ready_reg && !w_ready_reg && !bvalid_reg;
  assign wr_sel = ppc_decode(awaddr_reg);

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      aw_ready_reg <= 1'b1;
      w_ready_reg <= 1'b1;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= PPC_RESP_OKAY;
    end else begin
      if (aw_ready_reg && i_awvalid) begin
        awaddr_reg <= i_awaddr;
        aw_ready_reg <= 1'b0;
      end
      if (w_ready_reg && i_wvalid) begin
        wdata_reg <= i_wdata;
        wstrb_reg <= i_wstrb;
        w_ready_reg <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= (wr_sel == PPC_SEL_NONE) ? PPC_RESP_SLVERR : PPC_RESP_OKAY;
      end
      if (bvalid_reg && i_bready) begin
        bvalid_reg <= 1'b0;
        aw_ready_reg <= 1'b1;
        w_ready_reg <= 1'b1;
      end
    end
  end

  // Control fields; only lane 0 carries register data
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_reg.byte_timer_clk_on <= PPC_RST_PRESCALE[PPC_POS_BT_ON]; // R1
      ctrl_reg.byte_timer_div <= PPC_RST_PRESCALE[PPC_POS_BT_DIV +: 3]; // R2
      ctrl_reg.word_timer_b_src_sel <= PPC_RST_SRC_SEL[PPC_POS_SRC_B]; // R3
      ctrl_reg.word_timer_a_src_sel <= PPC_RST_SRC_SEL[PPC_POS_SRC_A]; // R3
      ctrl_reg.slow_out_on <= PPC_RST_FREQ_OUT[PPC_POS_SLOW_ON]; // R4
      ctrl_reg.slow_out_div <= PPC_RST_FREQ_OUT[PPC_POS_SLOW_DIV +: 3]; // R5
      ctrl_reg.fast_out_on <= PPC_RST_FREQ_OUT[PPC_POS_FAST_ON]; // R6
      ctrl_reg.fast_out_div <= PPC_RST_FREQ_OUT[PPC_POS_FAST_DIV +: 3]; // R7
      ctrl_reg.ext_clk_b_gate <= PPC_RST_EXT_GATE[PPC_POS_EXT_B]; // R8
      ctrl_reg.ext_clk_a_gate <= PPC_RST_EXT_GATE[PPC_POS_EXT_A]; // R9
    end else if (wr_fire && wstrb_reg[0]) begin
      // Bits not named below are simply not stored
      case (wr_sel)
        PPC_SEL_PRESCALE: begin
          ctrl_reg.byte_timer_clk_on <= wdata_reg[PPC_POS_BT_ON]; // R1
          ctrl_reg.byte_timer_div <= wdata_reg[PPC_POS_BT_DIV +: 3]; // R2
        end
        PPC_SEL_SRC: begin
          ctrl_reg.word_timer_b_src_sel <= wdata_reg[PPC_POS_SRC_B]; // R3
          ctrl_reg.word_timer_a_src_sel <= wdata_reg[PPC_POS_SRC_A]; // R3
        end
        PPC_SEL_FOUT: begin
          ctrl_reg.slow_out_on <= wdata_reg[PPC_POS_SLOW_ON]; // R4
          ctrl_reg.slow_out_div <= wdata_reg[PPC_POS_SLOW_DIV +: 3]; // R5
          ctrl_reg.fast_out_on <= wdata_reg[PPC_POS_FAST_ON]; // R6
          ctrl_reg.fast_out_div <= wdata_reg[PPC_POS_FAST_DIV +: 3]; // R7
        end
        PPC_SEL_EXT: begin
          ctrl_reg.ext_clk_b_gate <= wdata_reg[PPC_POS_EXT_B]; // R8
          ctrl_reg.ext_clk_a_gate <= wdata_reg[PPC_POS_EXT_A]; // R9
        end
        default: begin
          ctrl_reg <= ctrl_reg; // R10
        end
      endcase
    end
  end

  // Read channel: data one cycle after the address is taken
  assign rd_sel = ppc_decode(i_araddr);

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ar_ready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= PPC_RESP_OKAY;
    end else begin
      if (ar_ready_reg && i_arvalid) begin
        ar_ready_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rdata_reg <= {24'h000000, read_byte(rd_sel, ctrl_reg)}; // R10
        rresp_reg <= (rd_sel == PPC_SEL_NONE) ? PPC_RESP_SLVERR : PPC_RESP_OKAY;
      end
      if (rvalid_reg && i_rready) begin
        rvalid_reg <= 1'b0;
        ar_ready_reg <= 1'b1;
      end
    end
  end

  // Sources and enables for the gated clocks
  always_comb begin
    gate_src[G_BYTE] = fast_cnt[ctrl_reg.byte_timer_div]; // R2
    gate_src[G_SLOW] = tap_sel(slow_level, {1'b0, slow_cnt}, ctrl_reg.slow_out_div); // R5
    gate_src[G_FAST] = tap_sel(fast_level, fast_cnt, ctrl_reg.fast_out_div); // R7
    gate_src[G_EXTB] = ext_b_level;
    gate_src[G_EXTA] = ext_a_level;
    gate_on[G_BYTE] = ctrl_reg.byte_timer_clk_on;
    gate_on[G_SLOW] = ctrl_reg.slow_out_on;
    gate_on[G_FAST] = ctrl_reg.fast_out_on;
    gate_on[G_EXTB] = ctrl_reg.ext_clk_b_gate;
    gate_on[G_EXTA] = ctrl_reg.ext_clk_a_gate;
  end

  // Enable follows only while the source is low, so turning a gate on or off never cuts a pulse short
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      gate_act_reg <= '0;
      gate_out_reg <= '0;
    end else begin
      for (int g = 0; g < GATES; g++) begin
        if (!gate_src[g]) begin
          gate_act_reg[g] <= gate_on[g]; // R11
        end
        gate_out_reg[g] <= gate_act_reg[g] & gate_src[g]; // R1
      end
    end
  end

  // Word timer source selection
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      word_a_reg <= 1'b0;
      word_b_reg <= 1'b0;
    end else begin
      word_a_reg <= ctrl_reg.word_timer_a_src_sel ? slow_level : fast_level; // R3
      word_b_reg <= ctrl_reg.word_timer_b_src_sel ? slow_level : fast_level; // R3
    end
  end

  assign o_awready = aw_ready_reg;
  assign o_wready = w_ready_reg;
  assign o_bvalid = bvalid_reg;
  assign o_bresp = bresp_reg;
  assign o_arready = ar_ready_reg;
  assign o_rvalid = rvalid_reg;
  assign o_rdata = rdata_reg;
  assign o_rresp = rresp_reg;
  assign o_byte_timer_clk = gate_out_reg[G_BYTE];
  assign o_slow_freq_output = gate_out_reg[G_SLOW];
  assign o_fast_freq_output = gate_out_reg[G_FAST];
  assign o_ext_clk_b = gate_out_reg[G_EXTB];
  assign o_ext_clk_a = gate_out_reg[G_EXTA];
  assign o_word_timer_a_clk = word_a_reg;
  assign o_word_timer_b_clk = word_b_reg;

  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  sequence s_off_and_low(logic on, logic src);
    !on && !src;
  endsequence

  sequence s_write_taken;
    !o_awready && !o_wready && !o_bvalid;
  endsequence

  a_byte_clk_off: assert property ( // R1
    s_off_and_low(gate_on[G_BYTE], gate_src[G_BYTE]) |-> ##2 !o_byte_timer_clk)
    else $error("byte timer clock runs while disabled");

  a_byte_div_tap: assert property ( // R2
    $rose(o_byte_timer_clk) |-> $past(fast_cnt[ctrl_reg.byte_timer_div]))
    else $error("byte timer clock not from selected tap");

  a_word_src_sel: assert property ( // R3
    ##1 o_word_timer_a_clk ==
      $past(ctrl_reg.word_timer_a_src_sel ? slow_level : fast_level))
    else $error("word timer a source wrong");

  a_slow_out_off: assert property ( // R4
    s_off_and_low(gate_on[G_SLOW], gate_src[G_SLOW]) |-> ##2 !o_slow_freq_output)
    else $error("slow output runs while disabled");

  a_slow_div_one: assert property ( // R5
    (gate_act_reg[G_SLOW] && ctrl_reg.slow_out_div == 3'h0) [*2]
      |-> o_slow_freq_output == $past(slow_level))
    else $error("slow output /1 not following oscillator");

  a_fast_out_off: assert property ( // R6
    s_off_and_low(gate_on[G_FAST], gate_src[G_FAST]) |-> ##2 !o_fast_freq_output)
    else $error("fast output runs while disabled");

  a_fast_div_one: assert property ( // R7
    (gate_act_reg[G_FAST] && ctrl_reg.fast_out_div == 3'h0) [*2]
      |-> o_fast_freq_output == $past(fast_level))
    else $error("fast output /1 not following oscillator");

  a_ext_b_gate: assert property ( // R8
    s_off_and_low(gate_on[G_EXTB], gate_src[G_EXTB]) |-> ##2 !o_ext_clk_b)
    else $error("external clock b passes while gated");

  a_ext_a_gate: assert property ( // R9
    s_off_and_low(gate_on[G_EXTA], gate_src[G_EXTA]) |-> ##2 !o_ext_clk_a)
    else $error("external clock a passes while gated");

  a_unused_zero: assert property ( // R10
    (o_arready && i_arvalid) |=> o_rvalid && o_rdata[31:8] == 24'h000000 &&
      (o_rdata[7:4] == 4'h0 || $past(rd_sel) == PPC_SEL_FOUT))
    else $error("unassigned bits read nonzero");

  a_no_glitch_start: assert property ( // R11
    $rose(o_fast_freq_output) |-> $past(gate_src[G_FAST]) && !$past(gate_src[G_FAST], 2))
    else $error("fast output started outside a full high phase");

  a_write_resp: assert property (
    s_write_taken |=> o_bvalid)
    else $error("write response missing");

endmodule

// ===== rtl/ppc_pkg.sv
// Constants, field layout and carrier types of the prescaler and clock output control.
// Assumes a single 200 MHz system clock; oscillator and counter clocks arrive as pins.
//
// What this block does
// (R1) Byte timer clock enable gates the divided clock; resets to off.
// (R2) Byte timer divider picks fast oscillator /2 to /256; field resets to 000.
// (R3) Per word timer, select bit picks slow (1) or fast (0) oscillator.
// (R4) Slow frequency output enable: 1 drives divided clock, 0 stops; resets off.
// (R5) Slow output divider picks slow oscillator /1 to /128; resets to 000.
// (R6) Fast frequency output enable: 1 drives divided clock, 0 stops; resets off.
// (R7) Fast output divider picks fast oscillator /1 to /128; resets to 000.
// (R8) Gate bit passes second external counter clock when 1; resets off.
// (R9) Gate bit passes first external counter clock when 1; resets off.
// (R10) Unassigned bits ignore writes and read as zero.
// (R11) Disabled frequency outputs sit low; enabling starts without a glitch.
package ppc_pkg;

  // Bus geometry
  localparam int PPC_ADDR_W = 20;
  localparam int PPC_DATA_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [15:0] PPC_IDX_PRESCALE = 16'hff11;
  localparam logic [15:0] PPC_IDX_SRC_SEL = 16'hff12;
  localparam logic [15:0] PPC_IDX_FREQ_OUT = 16'hff14;
  localparam logic [15:0] PPC_IDX_EXT_GATE = 16'hff15;

  // Field positions
  localparam int PPC_POS_BT_ON = 3;
  localparam int PPC_POS_BT_DIV = 0;
  localparam int PPC_POS_SRC_B = 1;
  localparam int PPC_POS_SRC_A = 0;
  localparam int PPC_POS_SLOW_ON = 7;
  localparam int PPC_POS_SLOW_DIV = 4;
  localparam int PPC_POS_FAST_ON = 3;
  localparam int PPC_POS_FAST_DIV = 0;
  localparam int PPC_POS_EXT_B = 1;
  localparam int PPC_POS_EXT_A = 0;

  // Reset values
  localparam logic [7:0] PPC_RST_PRESCALE = 8'h00;
  localparam logic [7:0] PPC_RST_SRC_SEL = 8'h00;
  localparam logic [7:0] PPC_RST_FREQ_OUT = 8'h00;
  localparam logic [7:0] PPC_RST_EXT_GATE = 8'h00;

  // Timing: pin synchroniser depth
  localparam int PPC_SYNC_STAGES = 3;

  // AXI responses
  localparam logic [1:0] PPC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PPC_RESP_SLVERR = 2'h2;

  typedef enum {PPC_SEL_PRESCALE, PPC_SEL_SRC, PPC_SEL_FOUT, PPC_SEL_EXT, PPC_SEL_NONE} ppc_sel_t;

  typedef struct packed {
    logic byte_timer_clk_on;
    logic [2:0] byte_timer_div;
    logic word_timer_b_src_sel;
    logic word_timer_a_src_sel;
    logic slow_out_on;
    logic [2:0] slow_out_div;
    logic fast_out_on;
    logic [2:0] fast_out_div;
    logic ext_clk_b_gate;
    logic ext_clk_a_gate;
  } ppc_ctrl_t;

  // Address decode shared by read and write paths
  function automatic ppc_sel_t ppc_decode(input logic [PPC_ADDR_W-1:0] addr);
    ppc_sel_t sel;
    sel = PPC_SEL_NONE;
    if (addr[1:0] == 2'h0 && addr[PPC_ADDR_W-1:18] == 2'h0) begin
      if (addr[17:2] == PPC_IDX_PRESCALE) sel = PPC_SEL_PRESCALE;
      if (addr[17:2] == PPC_IDX_SRC_SEL) sel = PPC_SEL_SRC;
      if (addr[17:2] == PPC_IDX_FREQ_OUT) sel = PPC_SEL_FOUT;
      if (addr[17:2] == PPC_IDX_EXT_GATE) sel = PPC_SEL_EXT;
    end
    return sel;
  endfunction

endpackage

// ===== rtl/ppc_osc_tap.sv
// Pin synchroniser with a debounced level and a ripple-free count of rising edges.
// Assumes the pin toggles well below half the system clock rate.
`timescale 1ns/1ps
module ppc_osc_tap
  import ppc_pkg::*;
#(
  parameter int CNT_W = 8
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Pin
  input wire logic i_pin,
  // Accepted level and edge count
  output logic o_level,
  output logic [CNT_W-1:0] o_count
);

  logic [PPC_SYNC_STAGES-1:0] sync_reg;

  initial begin
    if (CNT_W < 1 || CNT_W > 16) $error("ppc_osc_tap: CNT_W out of range");
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= {sync_reg[PPC_SYNC_STAGES-2:0], i_pin};
    end
  end

  // Change accepted once second and third stages agree
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_level <= 1'b0;
      o_count <= '0;
    end else if (sync_reg[1] == sync_reg[2] && sync_reg[2] != o_level) begin
      o_level <= sync_reg[2];
      if (sync_reg[2]) begin
        o_count <= o_count + CNT_W'(1);
      end
    end
  end

endmodule

// ===== testbench/tb.sv
// Self-checking bench for the prescaler and clock output control block.
// Assumes ppc_pkg and ppc_clock_ctrl are compiled first; the bench drives every port.
`timescale 1ns/1ps
module tb
  import ppc_pkg::*;
;
  localparam int LIMIT = 90000;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_awvalid = 1'b0;
  logic [PPC_ADDR_W-1:0] i_awaddr = '0;
  logic i_wvalid = 1'b0;
  logic [PPC_DATA_W-1:0] i_wdata = '0;
  logic [3:0] i_wstrb = 4'h0;
  logic i_bready = 1'b0;
  logic i_arvalid = 1'b0;
  logic [PPC_ADDR_W-1:0] i_araddr = '0;
  logic i_rready = 1'b0;
  logic [3:0] pins = 4'h0;
  int cnt[4] = '{0, 0, 0, 0};
  int half[4] = '{8, 10, 9, 11};
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0] o_bresp, o_rresp;
  logic [PPC_DATA_W-1:0] o_rdata;
  logic o_byte_timer_clk, o_word_timer_a_clk, o_word_timer_b_clk;
  logic o_ext_clk_a, o_ext_clk_b, o_slow_freq_output, o_fast_freq_output;
  logic [6:0] outs;
  logic [1:0] exp_b[$];
  logic [33:0] exp_r[$];
  logic [33:0] eb, er;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  logic [PPC_ADDR_W-1:0] ra[4];
  logic [7:0] mask[4] = '{8'h0f, 8'h03, 8'hff, 8'h03};
  logic [31:0] d;

  assign ra[0] = {2'h0, PPC_IDX_PRESCALE, 2'h0};
  assign ra[1] = {2'h0, PPC_IDX_SRC_SEL, 2'h0};
  assign ra[2] = {2'h0, PPC_IDX_FREQ_OUT, 2'h0};
  assign ra[3] = {2'h0, PPC_IDX_EXT_GATE, 2'h0};
  // Index order: byte, slow, fast, ext a, ext b, word a, word b
  assign outs = {o_word_timer_b_clk, o_word_timer_a_clk, o_ext_clk_b, o_ext_clk_a,
                 o_fast_freq_output, o_slow_freq_output, o_byte_timer_clk};

  ppc_clock_ctrl i_dut (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr), .i_awprot(3'h0),
    .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
    .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
    .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr), .i_arprot(3'h0),
    .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .i_slow_osc_freq(pins[1]), .i_fast_osc_freq(pins[0]),
    .i_ext_counter_clk_a(pins[2]), .i_ext_counter_clk_b(pins[3]),
    .o_byte_timer_clk(o_byte_timer_clk), .o_word_timer_a_clk(o_word_timer_a_clk),
    .o_word_timer_b_clk(o_word_timer_b_clk), .o_ext_clk_a(o_ext_clk_a),
    .o_ext_clk_b(o_ext_clk_b), .o_slow_freq_output(o_slow_freq_output),
    .o_fast_freq_output(o_fast_freq_output)
  );

  initial begin
    forever #2.5 i_clock = ~i_clock;
  end

  // Oscillator and counter pins: fast 16, slow 20, ext a 18, ext b 22 cycles a period
  always @(posedge i_clock) begin
    for (int p = 0; p < 4; p++) begin
      if (cnt[p] == half[p] - 1) begin
        cnt[p] <= 0;
        pins[p] <= ~pins[p];
      end else begin
        cnt[p] <= cnt[p] + 1;
      end
    end
  end

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [19:0] a, input logic [31:0] dd, input logic [3:0] s,
                    input logic [1:0] r);
    int n;
    n = 0;
    exp_b.push_back(r);
    @(posedge i_clock);
    i_awaddr <= a;
    i_wdata <= dd;
    i_wstrb <= s;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do begin
      @(posedge i_clock);
      n++;
      if (o_awready === 1'b1) i_awvalid <= 1'b0;
      if (o_wready === 1'b1) i_wvalid <= 1'b0;
    end while (o_bvalid !== 1'b1 && n < 1000);
    i_bready <= 1'b0;
    if (n >= 1000) chk(34'h0, 34'h1);
  endtask

  task automatic rd(input logic [19:0] a, input logic [31:0] dd, input logic [1:0] r);
    int n;
    n = 0;
    exp_r.push_back({r, dd});
    @(posedge i_clock);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do begin
      @(posedge i_clock);
      n++;
      if (o_arready === 1'b1) i_arvalid <= 1'b0;
    end while (o_rvalid !== 1'b1 && n < 1000);
    i_rready <= 1'b0;
    if (n >= 1000) chk(34'h0, 34'h1);
  endtask

  // Cycles between the second and third rising edge of an output
  task automatic meas(input int k, input int exp);
    int n, t2, r;
    logic p;
    n = 0;
    t2 = 0;
    r = 0;
    p = outs[k];
    while (r < 3 && n < 20000) begin
      @(posedge i_clock);
      n++;
      if (outs[k] === 1'b1 && p === 1'b0) begin
        r++;
        if (r == 2) t2 = n;
      end
      p = outs[k];
    end
    chk(34'(n - t2), 34'(exp));
  endtask

  // Let a running high phase finish, then gated outputs must stay low
  task automatic quiet();
    logic [4:0] seen;
    seen = 5'h0;
    repeat (2600) @(posedge i_clock);
    repeat (300) begin
      @(posedge i_clock);
      seen = seen | outs[4:0];
    end
    chk({29'h0, seen}, 34'h0);
  endtask

  // Responses are matched against the oldest noted expectation
  always @(posedge i_clock) begin
    if (o_bvalid === 1'b1 && i_bready === 1'b1) begin
      eb = exp_b.size() > 0 ? {32'h0, exp_b.pop_front()} : 'x;
      chk({32'h0, o_bresp}, eb);
    end
    if (o_rvalid === 1'b1 && i_rready === 1'b1) begin
      er = exp_r.size() > 0 ? exp_r.pop_front() : 'x;
      chk({o_rresp, o_rdata}, er);
    end
  end

  always @(posedge i_clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      results();
    end
  end

  initial begin
    void'($urandom(32'ha9d6));
    repeat (10) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    for (int k = 0; k < 4; k++) rd(ra[k], 32'h0, PPC_RESP_OKAY);
    for (int k = 0; k < 12; k++) begin
      d = $urandom;
      wr(ra[k % 4], d, 4'hf, PPC_RESP_OKAY);
      rd(ra[k % 4], {24'h0, d[7:0] & mask[k % 4]}, PPC_RESP_OKAY);
      wr(ra[k % 4], ~d, 4'he, PPC_RESP_OKAY);
      rd(ra[k % 4], {24'h0, d[7:0] & mask[k % 4]}, PPC_RESP_OKAY);
    end
    wr(ra[1] + 20'h4, 32'hff, 4'hf, PPC_RESP_SLVERR);
    rd(ra[1] + 20'h4, 32'h0, PPC_RESP_SLVERR);
    rd(ra[0] + 20'h1, 32'h0, PPC_RESP_SLVERR);
    wr(ra[1], 32'h0, 4'hf, PPC_RESP_OKAY);
    meas(5, 16);
    meas(6, 16);
    wr(ra[1], 32'h3, 4'hf, PPC_RESP_OKAY);
    meas(5, 20);
    meas(6, 20);
    wr(ra[1], 32'h1, 4'hf, PPC_RESP_OKAY);
    meas(5, 20);
    meas(6, 16);
    for (int c = 0; c < 8; c++) begin
      wr(ra[0], 32'(8 + c), 4'hf, PPC_RESP_OKAY);
      meas(0, 32 << c);
      wr(ra[2], 32'(8 + c), 4'hf, PPC_RESP_OKAY);
      meas(2, 16 << c);
      wr(ra[2], 32'(8'h80 | (c << 4)), 4'hf, PPC_RESP_OKAY);
      meas(1, 20 << c);
    end
    wr(ra[3], 32'h1, 4'hf, PPC_RESP_OKAY);
    meas(3, 18);
    wr(ra[3], 32'h2, 4'hf, PPC_RESP_OKAY);
    meas(4, 22);
    wr(ra[0], 32'h7, 4'hf, PPC_RESP_OKAY);
    wr(ra[2], 32'h77, 4'hf, PPC_RESP_OKAY);
    wr(ra[3], 32'h0, 4'hf, PPC_RESP_OKAY);
    quiet();
    repeat (5) @(posedge i_clock);
    results();
  end
endmodule
